// ---- src/dtp_pkg.sv ----
// Package for the down timer with PWM: register map, fields, reset values
package dtp_pkg;
   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [2:0] DTP_OFS_COUNT   = 3'h0;
   localparam logic [2:0] DTP_OFS_MODE    = 3'h1;
   localparam logic [2:0] DTP_OFS_CLOCK   = 3'h2;
   localparam logic [2:0] DTP_OFS_DUTY    = 3'h3;
   localparam logic [2:0] DTP_OFS_PRESC   = 3'h4;
   localparam logic [2:0] DTP_OFS_HIGH    = 3'h5;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int DTP_BIT_RUN      = 0;
   localparam int DTP_BIT_RELOAD   = 1;
   localparam int DTP_BIT_ONESHOT  = 2;
   localparam int DTP_BIT_POL      = 6;
   localparam int DTP_BIT_PINEN    = 7;
   localparam int DTP_BIT_PSEN_N   = 3;
   localparam int DTP_BIT_EDGE     = 4;
   localparam int DTP_BIT_SRC      = 5;

   // -------------------------------------------------------------
   // Reset values and constants
   // -------------------------------------------------------------
   localparam logic [7:0] DTP_MODE_RST   = 8'h00;
   localparam logic [7:0] DTP_CLOCK_RST  = 8'h3F;
   localparam logic [7:0] DTP_PRESC_RST  = 8'hFF;
   localparam logic [9:0] DTP_CNT_MAX    = 10'h3FF;
   localparam logic [9:0] DTP_CNT_ZERO   = 10'h000;
   localparam logic [7:0] DTP_MODE_MASK  = 8'hC7;
   localparam logic [7:0] DTP_CLOCK_MASK = 8'h3F;
   localparam logic [7:0] DTP_HIGH_MASK  = 8'h33;

   // Register read/write request carrier
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] data;
      logic       wr;
      logic       rd;
   } dtp_req_s;
endpackage

// ---- src/dtp_timer.sv ----
// Ten-bit down timer with prescaler and PWM output
//
// Behaviour
// - Ten-bit down counter, count reads live value
// - Count write loads reload and live counter
// - Run bit gates counting, resets to zero
// - Non-stop, no reload: wrap to 0x3FF
// - Non-stop with reload: reload on underflow
// - One-shot counts to zero then stops
// - Polarity bit selects PWM active level
// - Pin enable routes PWM onto port pin
// - Prescaler divides by two to field-plus-one
// - Edge bit picks falling or rising edges
// - Source bit picks external pin, resets one
// - Frame from reload, duty from high+duty
// - Prescaler count readable, resets all ones
//
// The plain strobed port was decided locally.
module dtp_timer
   import dtp_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       ce_i,
   // Register port
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // Pins
   input  wire logic       ext_clk_i,
   input  wire logic       gpio_out_i,
   input  wire logic       gpio_oe_i,
   output logic            pwm_pin_o,
   output logic            pwm_pin_oe_o,
   output logic            pwm_o
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   dtp_req_s   req;
   logic [7:0] mode_reg, next_mode_reg;
   logic [7:0] clk_reg, next_clk_reg;
   logic [7:0] duty_low, next_duty_low;
   logic [7:0] high_reg, next_high_reg;
   logic [7:0] reload_low, next_reload_low;
   logic [9:0] count, next_count;
   logic [7:0] presc, next_presc;
   logic       stopped, next_stopped;
   logic [7:0] rdata, next_rdata;
   logic       pin, next_pin, pin_oe, next_pin_oe, pwm, next_pwm;
   // Pin synchroniser taps and tick qualifiers
   logic       ext_s1, ext_s2, ext_s3;
   logic       ext_edge, tick_src, tick;
   // Ten-bit words assembled from the shared high register
   logic [9:0] reload_val, duty_val;

   // Bundle the bus inputs so the decode reads them as one request
   assign req = '{addr: addr_i, data: wdata_i, wr: wr_i, rd: rd_i};

   // Mask of prescaler bits whose all-ones state ends a division step
   function automatic logic [7:0] div_mask(input logic [2:0] sel);
      div_mask = 8'(({1'b0, 8'hFF} << (4'(sel) + 4'h1)) >> 9'h000);
      div_mask = ~div_mask;
   endfunction

   // -------------------------------------------------------------
   // Input synchroniser for the external count pin
   // -------------------------------------------------------------
   // Third stage feeds the edge detector so the first stage stays clean
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else if (ce_i) begin
         ext_s1 <= ext_clk_i;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   // Edge choice and clock source choice
   always_comb begin
      ext_edge = clk_reg[DTP_BIT_EDGE] ? (ext_s3 & ~ext_s2)
                                       : (~ext_s3 & ext_s2);
      tick_src = clk_reg[DTP_BIT_SRC] ? ext_edge : 1'b1;
   end

   // Values built from the shared high register
   assign reload_val = {high_reg[5:4], reload_low};
   assign duty_val   = {high_reg[1:0], duty_low};

   // -------------------------------------------------------------
   // Prescaler: a tick leaves it when the selected low bits are all ones
   // -------------------------------------------------------------
   // Counts only while running; a divider changed while enabled can cut a period short
   always_comb begin
      next_presc = presc;
      tick       = 1'b0;
      if (mode_reg[DTP_BIT_RUN] && tick_src) begin
         if (clk_reg[DTP_BIT_PSEN_N]) begin
            tick = 1'b1;                                      // Bypassed
         end else begin
            next_presc = presc + 8'h01;
            tick = ((presc & div_mask(clk_reg[2:0])) ==
                    div_mask(clk_reg[2:0]));
         end
      end
   end

   // -------------------------------------------------------------
   // Registers, counter and PWM next values
   // -------------------------------------------------------------
   always_comb begin
      next_mode_reg   = mode_reg;
      next_clk_reg    = clk_reg;
      next_duty_low   = duty_low;
      next_high_reg   = high_reg;
      next_reload_low = reload_low;
      next_count      = count;
      next_stopped    = stopped;
      next_rdata      = 8'h00;
      // Counting; halted while the run bit is low
      if (tick && !stopped) begin
         if (count == DTP_CNT_ZERO) begin
            if (mode_reg[DTP_BIT_ONESHOT]) begin
               next_stopped = 1'b1;
            end else if (mode_reg[DTP_BIT_RELOAD]) begin
               next_count = reload_val;
            end else begin
               next_count = DTP_CNT_MAX;
            end
         end else begin
            next_count = count - 10'h001;
         end
      end
      // Register writes take priority over counting, except a run-bit restart, which loses to an underflow stop
      if (req.wr) begin
         case (req.addr)
            DTP_OFS_COUNT: begin
               next_reload_low = req.data;
               next_count      = {high_reg[5:4], req.data};
               next_stopped    = 1'b0;
            end
            DTP_OFS_MODE: begin
               next_mode_reg = req.data & DTP_MODE_MASK;
               // An underflow stop set in this same cycle wins over the restart
               if (req.data[DTP_BIT_RUN] && (next_stopped == stopped)) begin
                  next_stopped = 1'b0;
               end
            end
            DTP_OFS_CLOCK: begin
               // Divider is assumed changed only while bypassed
               next_clk_reg = req.data & DTP_CLOCK_MASK;
            end
            DTP_OFS_DUTY: begin
               next_duty_low = req.data;
            end
            DTP_OFS_HIGH: begin
               next_high_reg = req.data & DTP_HIGH_MASK;
            end
            default: begin
            end
         endcase
      end
      // Read data, one cycle after the strobe
      if (req.rd) begin
         case (req.addr)
            DTP_OFS_COUNT: next_rdata = count[7:0];
            DTP_OFS_MODE:  next_rdata = mode_reg;
            DTP_OFS_CLOCK: next_rdata = clk_reg;
            DTP_OFS_DUTY:  next_rdata = duty_low;
            DTP_OFS_PRESC: next_rdata = presc;
            DTP_OFS_HIGH:  next_rdata = {2'b00, count[9:8], 2'b00, high_reg[1:0]};
            default:       next_rdata = 8'h00;
         endcase
      end
   end

   // PWM level and pin routing
   // Level trails the counter by one cycle so the pin and pwm_o stay aligned
   always_comb begin
      next_pwm    = (count <= duty_val) ^ mode_reg[DTP_BIT_POL];
      next_pin    = mode_reg[DTP_BIT_PINEN] ? next_pwm : gpio_out_i;
      next_pin_oe = mode_reg[DTP_BIT_PINEN] ? 1'b1 : gpio_oe_i;
   end

   // -------------------------------------------------------------
   // State registers
   // -------------------------------------------------------------
   // Everything holds while ce_i is low; reset does not wait for the enable
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_reg   <= DTP_MODE_RST;
         clk_reg    <= DTP_CLOCK_RST;
         duty_low   <= 8'h00;
         high_reg   <= 8'h00;
         reload_low <= 8'h00;
         count      <= DTP_CNT_ZERO;
         presc      <= DTP_PRESC_RST;
         stopped    <= 1'b0;
         rdata      <= 8'h00;
         pwm        <= 1'b0;
         pin        <= 1'b0;
         pin_oe     <= 1'b0;
      end else if (ce_i) begin
         mode_reg   <= next_mode_reg;
         clk_reg    <= next_clk_reg;
         duty_low   <= next_duty_low;
         high_reg   <= next_high_reg;
         reload_low <= next_reload_low;
         count      <= next_count;
         presc      <= next_presc;
         stopped    <= next_stopped;
         rdata      <= next_rdata;
         pwm        <= next_pwm;
         pin        <= next_pin;
         pin_oe     <= next_pin_oe;
      end
   end

   // Outputs come straight from their flops
   assign rdata_o      = rdata;
   assign pwm_o        = pwm;
   assign pwm_pin_o    = pin;
   assign pwm_pin_oe_o = pin_oe;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   a_halt_when_off: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && !mode_reg[DTP_BIT_RUN] && !wr_i) |=> $stable(count))
      else $error("counter moved while halted");
   a_write_loads: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && wr_i && addr_i == DTP_OFS_COUNT) |=>
      count == {$past(high_reg[5:4]), $past(wdata_i)})
      else $error("count write did not load counter");
   a_wrap_max: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && tick && !stopped && !wr_i && count == DTP_CNT_ZERO &&
       mode_reg[2:1] == 2'b00) |=> count == DTP_CNT_MAX)
      else $error("no wrap to max");
   a_reload_under: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && tick && !stopped && !wr_i && count == DTP_CNT_ZERO &&
       mode_reg[2:1] == 2'b01) |=> count == $past(reload_val))
      else $error("no reload on underflow");
   a_oneshot_stop: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && tick && !wr_i && count == DTP_CNT_ZERO &&
       mode_reg[DTP_BIT_ONESHOT]) |=> stopped && count == DTP_CNT_ZERO)
      else $error("one-shot did not stop");
   a_pwm_level: assert property (@(posedge clk_i) disable iff (srst_i)
      ce_i |=> pwm == (($past(count) <= $past(duty_val)) ^ $past(mode_reg[DTP_BIT_POL])))
      else $error("pwm level wrong");
   a_pin_route: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && mode_reg[DTP_BIT_PINEN]) |=> pwm_pin_oe_o && pwm_pin_o == pwm_o)
      else $error("pwm not routed to pin");
   a_bypass_tick: assert property (@(posedge clk_i) disable iff (srst_i)
      (mode_reg[DTP_BIT_RUN] && !clk_reg[DTP_BIT_SRC] && clk_reg[DTP_BIT_PSEN_N]) |-> tick)
      else $error("bypassed internal source did not tick");
   a_presc_read: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && rd_i && addr_i == DTP_OFS_PRESC) |=> rdata_o == $past(presc))
      else $error("prescaler read wrong");

   // -------------------------------------------------------------
   // Reset, register access and counting checks
   // -------------------------------------------------------------
   // Sync reset lands the documented values whatever ce_i does
   a_reset_values: assert property (@(posedge clk_i)
      srst_i |=> mode_reg == DTP_MODE_RST && clk_reg == DTP_CLOCK_RST &&
      presc == DTP_PRESC_RST && count == DTP_CNT_ZERO)
      else $error("reset values wrong");
   a_count_read: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && rd_i && addr_i == DTP_OFS_COUNT) |=> rdata_o == $past(count[7:0]))
      else $error("count read did not return live value");
   // A plain tick away from zero must step down by exactly one
   a_count_down: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && tick && !stopped && !wr_i && count != DTP_CNT_ZERO) |=>
      count == $past(count) - 10'h001)
      else $error("counter did not step down");
   a_stop_holds: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && stopped && !wr_i) |=> stopped && $stable(count))
      else $error("stopped one-shot moved");
   // Edge recomputed from the synchroniser taps, not from the select logic
   a_edge_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && clk_reg[DTP_BIT_SRC] && !wr_i &&
       !(clk_reg[DTP_BIT_EDGE] ? (ext_s3 && !ext_s2) : (!ext_s3 && ext_s2))) |=>
      $stable(count) && $stable(presc))
      else $error("counter moved without a selected pin edge");
   a_edge_counts: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && mode_reg[DTP_BIT_RUN] && clk_reg[DTP_BIT_SRC] && clk_reg[DTP_BIT_PSEN_N] &&
       !stopped && !wr_i && count != DTP_CNT_ZERO && ext_edge) |=>
      count == $past(count) - 10'h001)
      else $error("selected pin edge did not step the counter");
   // Low enable freezes the block; the bench drops it in mid-count
   a_ce_freeze: assert property (@(posedge clk_i) disable iff (srst_i)
      (!ce_i && !srst_i) |=> $stable(count) && $stable(presc) && $stable(mode_reg) &&
      $stable(rdata_o) && $stable(pwm_o))
      else $error("state moved while clock enable low");

   // -------------------------------------------------------------
   // Pin routing checks
   // -------------------------------------------------------------
   a_pin_gpio: assert property (@(posedge clk_i) disable iff (srst_i)
      (ce_i && !mode_reg[DTP_BIT_PINEN]) |=>
      pwm_pin_o == $past(gpio_out_i) && pwm_pin_oe_o == $past(gpio_oe_i))
      else $error("port pin not left to general purpose logic");
endmodule

// ---- tb/dtp_timer_tb_top.sv ----
// Self-checking bench for the down timer with PWM
module dtp_timer_tb_top import dtp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Bench signals and counters
   // ----------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic [2:0]  addr_i = 3'h0;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [7:0]  rdata_o;
   logic        ext_clk_i = 1'b0;
   logic        gpio_out_i = 1'b0;
   logic        gpio_oe_i = 1'b0;
   logic        pwm_pin_o;
   logic        pwm_pin_oe_o;
   logic        pwm_o;
   int          err_total = 0;
   int          samples_checked = 0;
   logic [31:0] seed = 32'h0000_0053;
   logic [7:0]  rv;

`define DTP_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

   // Free-running 250 MHz clock
   always #2 clk_i = ~clk_i;

   dtp_timer dtp_timer_i (
      .clk_i        (clk_i),
      .srst_i       (srst_i),
      .ce_i         (ce_i),
      .addr_i       (addr_i),
      .wdata_i      (wdata_i),
      .wr_i         (wr_i),
      .rd_i         (rd_i),
      .rdata_o      (rdata_o),
      .ext_clk_i    (ext_clk_i),
      .gpio_out_i   (gpio_out_i),
      .gpio_oe_i    (gpio_oe_i),
      .pwm_pin_o    (pwm_pin_o),
      .pwm_pin_oe_o (pwm_pin_oe_o),
      .pwm_o        (pwm_o)
   );

   // ----------------------------------------------------------------
   // Helpers: random source, counter model, bus cycles
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Counter after d ticks from load l; wrap, reload or stop at zero
   function automatic logic [9:0] mdl(input logic [9:0] l, input int d, input bit rl, input bit os);
      logic [9:0] c;
      c = l;
      repeat (d) if (c == 10'h000) begin
         if (!os) c = rl ? l : 10'h3FF;
      end else c = c - 10'h001;
      return c;
   endfunction

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i) begin addr_i <= a; wdata_i <= d; wr_i <= 1'b1; end
      @(posedge clk_i) wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i) begin addr_i <= a; rd_i <= 1'b1; end
      @(posedge clk_i) rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   // High byte first, since a count write pulls its top bits from it
   task automatic load(input logic [9:0] c, input logic [9:0] du);
      wr(DTP_OFS_HIGH, {2'b00, c[9:8], 2'b00, du[9:8]});
      wr(DTP_OFS_COUNT, c[7:0]);
      wr(DTP_OFS_DUTY, du[7:0]);
   endtask

   task automatic chk_cnt(input logic [9:0] e);
      rd(DTP_OFS_COUNT, rv);
      `DTP_CHK(rv, e[7:0])
      rd(DTP_OFS_HIGH, rv);
      `DTP_CHK(rv[5:4], e[9:8])
   endtask

   // Timer runs for k+2 cycles between the two mode writes
   task automatic run_seg(input logic [7:0] m, input int k);
      wr(DTP_OFS_MODE, m | 8'h01);
      repeat (k) @(posedge clk_i);
      wr(DTP_OFS_MODE, m & 8'hFE);
   endtask

   task automatic summarize();
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Guard against a hang
   initial begin
      #300000;
      err_total++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [9:0]  l;
      logic [9:0]  du;
      logic [7:0]  m;
      logic [7:0]  p0;
      logic        ep;
      int          k;
      int          n;
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(DTP_OFS_MODE, rv);
      `DTP_CHK(rv, DTP_MODE_RST)
      rd(DTP_OFS_CLOCK, rv);
      `DTP_CHK(rv, DTP_CLOCK_RST)
      wr(DTP_OFS_PRESC, 8'h12);
      rd(DTP_OFS_PRESC, rv);
      `DTP_CHK(rv, DTP_PRESC_RST)
      rd(3'h6, rv);
      `DTP_CHK(rv, 8'h00)
      // Count modes: plain wrap, reload, one-shot, one-shot with reload
      wr(DTP_OFS_CLOCK, 8'h08);
      for (int i = 0; i < 16; i++) begin
         r = xs();
         l = {6'h00, r[3:0]};
         k = int'(r[8:4] % 30);
         m = {5'h00, 2'(i % 4), 1'b0};
         load(l, 10'h000);
         chk_cnt(l);
         run_seg(m, k);
         chk_cnt(mdl(l, k + 2, m[1], m[2]));
      end
      // Clock enable low in mid-count: only the three enabled edges may tick
      load(10'h100, 10'h000);
      wr(DTP_OFS_MODE, 8'h01);
      @(posedge clk_i) ce_i <= 1'b0;
      repeat (4 + int'(xs() % 8)) @(posedge clk_i);
      ce_i <= 1'b1;
      wr(DTP_OFS_MODE, 8'h00);
      chk_cnt(mdl(10'h100, 3, 1'b0, 1'b0));
      // Every divider: divider changed only while bypassed
      for (int s = 0; s < 8; s++) begin
         wr(DTP_OFS_CLOCK, 8'h08 | 8'(s));
         wr(DTP_OFS_CLOCK, 8'(s));
         load(10'h3F0, 10'h000);
         rd(DTP_OFS_PRESC, p0);
         n = 2 << s;
         run_seg(8'h00, 2 * n - 2);
         chk_cnt(10'h3EE);
         rd(DTP_OFS_PRESC, rv);
         `DTP_CHK(rv, p0 + 8'(2 * n))
         // Bypass again so the next divider change happens while bypassed
         wr(DTP_OFS_CLOCK, 8'h08 | 8'(s));
      end
      // External pin: one more rising than falling edge
      for (int e = 0; e < 2; e++) begin
         wr(DTP_OFS_CLOCK, 8'h28 | 8'(e << 4));
         load(10'h200, 10'h000);
         n = 3 + int'(xs() % 4);
         wr(DTP_OFS_MODE, 8'h01);
         for (int j = 0; j <= n; j++) begin
            @(posedge clk_i) ext_clk_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            if (j < n) ext_clk_i <= 1'b0;
            repeat (4) @(posedge clk_i);
         end
         repeat (8) @(posedge clk_i);
         wr(DTP_OFS_MODE, 8'h00);
         chk_cnt(10'h200 - 10'(e ? n : n + 1));
         @(posedge clk_i) ext_clk_i <= 1'b0;
      end
      // PWM level, polarity and pin routing with the timer halted
      for (int i = 0; i < 16; i++) begin
         r = xs();
         l = r[9:0];
         du = (i % 4 == 0) ? l : r[25:16];
         load(l, du);
         wr(DTP_OFS_MODE, {i[1], i[0], 6'h00});
         @(posedge clk_i) begin gpio_out_i <= r[30]; gpio_oe_i <= r[31]; end
         repeat (3) @(posedge clk_i);
         #1 ep = (l <= du) ^ i[0];
         `DTP_CHK(pwm_o, ep)
         `DTP_CHK(pwm_pin_o, i[1] ? ep : r[30])
         `DTP_CHK(pwm_pin_oe_o, i[1] ? 1'b1 : r[31])
      end
      summarize();
   end
endmodule
